// *** tsrb_readback.sv ***
`timescale 1ns/10ps
// What this block does
// [RULE_01] frequency reads as 1000 GHz word and 0.1 GHz word
// [RULE_02] frequency pair always matches channel, grid and first channel; a result below zero reads as zero instead
// [RULE_03] output power reads signed, thousandths of a dBm
// [RULE_04] temperature reads as hundredths of a degree Celsius
// [RULE_05] temperature alarm compares held temperature with set point
// [RULE_06] power min and max appear once a channel is selected
// [RULE_07] lowest and highest frequency read as high/low pairs
// [RULE_08] minimum channel spacing reads in grid spacing format
// [RULE_09] addresses 0x57 to 0x7F reserved, read zero, no function
// [RULE_10] upper half of the map goes to maker-specific logic
// [RULE_11] spacing values are signed, units of 100 MHz
// [RULE_12] frequency is (channel minus one) times grid plus first
// [RULE_13] writes to these read-only registers change nothing
module tsrb_readback
(
  // clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_sys_rst,
  // register port
  input  wire tsrb_pkg::tsrb_req_t    i_req,
  output logic [15:0]                 o_rdata,
  output logic                        o_rvalid,
  output logic                        o_wr_ignored,
  // tuning state and measurements
  input  wire tsrb_pkg::tsrb_tune_t   i_tune,
  input  wire logic [15:0]            i_power_meas,
  input  wire logic [15:0]            i_temp_meas,
  input  wire logic [15:0]            i_power_min,
  input  wire logic [15:0]            i_power_max,
  input  wire tsrb_pkg::tsrb_caps_t   i_caps,
  // maker-specific area
  output logic                        o_maker_rd,
  output logic                        o_maker_wr,
  output logic [7:0]                  o_maker_addr,
  output logic [15:0]                 o_maker_wdata,
  input  wire logic [15:0]            i_maker_rdata,
  // alarm
  output logic                        o_temp_alarm
);

  tsrb_pkg::tsrb_freq_t next_freq;
  tsrb_pkg::tsrb_freq_t freq;
  tsrb_pkg::tsrb_caps_t caps;
  logic [15:0]          power;
  logic [15:0]          temp;
  logic [15:0]          power_min;
  logic [15:0]          power_max;
  logic [15:0]          next_rdata;

  // address in the maker-specific half
  function automatic logic is_maker(input logic [7:0] a);
    is_maker = (a >= tsrb_pkg::MAKER_FIRST);
  endfunction : is_maker

  // address in the reserved gap
  function automatic logic is_rsvd(input logic [7:0] a);
    is_rsvd = (a >= tsrb_pkg::RSVD_FIRST) && (a <= tsrb_pkg::RSVD_LAST);
  endfunction : is_rsvd

  // set point from the tuning state
  tsrb_freq_calc u_freq_calc
  (
    .i_tune (i_tune),
    .o_freq (next_freq)
  );

  // alarm from the held temperature word
  tsrb_temp_alarm u_temp_alarm
  (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_temp     (temp),
    .o_alarm    (o_temp_alarm)  // RULE_05
  );

  // frequency pair follows the set point, also while in reset
  always_ff @(posedge i_core_clk)
  begin
    freq <= next_freq;  // RULE_01 RULE_02 RULE_11 RULE_12
  end

  // measured power, signed thousandths of a dBm
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      power <= tsrb_pkg::ZERO_WORD;
    else
      power <= i_power_meas;  // RULE_03
  end

  // measured temperature, hundredths of a degree
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      temp <= tsrb_pkg::ZERO_WORD;
    else
      temp <= i_temp_meas;  // RULE_04
  end

  // power range, loaded only with a channel selected
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      power_min <= tsrb_pkg::ZERO_WORD;
      power_max <= tsrb_pkg::ZERO_WORD;
    end
    else if (i_tune.channel != tsrb_pkg::NO_CHANNEL)
    begin
      power_min <= i_power_min;  // RULE_06
      power_max <= i_power_max;  // RULE_06
    end
  end

  // capabilities held in the register file
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      caps <= '0;
    else
      caps <= i_caps;  // RULE_07 RULE_08 RULE_11
  end

  // read select
  always_comb
  begin
    next_rdata = tsrb_pkg::ZERO_WORD;
    case (i_req.addr)
      tsrb_pkg::FREQ_HI_OFS:  next_rdata = freq.hi;             // RULE_01
      tsrb_pkg::FREQ_LO_OFS:  next_rdata = freq.lo;             // RULE_01
      tsrb_pkg::PWR_OFS:      next_rdata = power;               // RULE_03
      tsrb_pkg::TEMP_OFS:     next_rdata = temp;                // RULE_04
      tsrb_pkg::PWR_MIN_OFS:  next_rdata = power_min;           // RULE_06
      tsrb_pkg::PWR_MAX_OFS:  next_rdata = power_max;           // RULE_06
      tsrb_pkg::LOW_HI_OFS:   next_rdata = caps.lowest.hi;      // RULE_07
      tsrb_pkg::LOW_LO_OFS:   next_rdata = caps.lowest.lo;      // RULE_07
      tsrb_pkg::HIGH_HI_OFS:  next_rdata = caps.highest.hi;     // RULE_07
      tsrb_pkg::HIGH_LO_OFS:  next_rdata = caps.highest.lo;     // RULE_07
      tsrb_pkg::MIN_SPC_OFS:  next_rdata = caps.min_spacing;    // RULE_08
      default:
      begin
        if (is_maker(i_req.addr))
          next_rdata = i_maker_rdata;        // RULE_10
        else if (is_rsvd(i_req.addr))
          next_rdata = tsrb_pkg::ZERO_WORD;  // RULE_09
        else
          next_rdata = tsrb_pkg::ZERO_WORD;
      end
    endcase
  end

  // maker-area strobes pass straight through
  always_comb
  begin
    o_maker_rd    = i_req.rd && is_maker(i_req.addr);  // RULE_10
    o_maker_wr    = i_req.wr && is_maker(i_req.addr);  // RULE_10
    o_maker_addr  = i_req.addr;
    o_maker_wdata = i_req.wdata;
  end

  // registered read data and valid pulse
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_rdata  <= tsrb_pkg::ZERO_WORD;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_req.rd;
      if (i_req.rd)
        o_rdata <= next_rdata;
    end
  end

  // writes below the maker area are dropped and flagged
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_wr_ignored <= 1'b0;
    else
      o_wr_ignored <= i_req.wr && !is_maker(i_req.addr);  // RULE_13
  end

endmodule : tsrb_readback

// *** tsrb_pkg.sv ***
package tsrb_pkg;

  // register word and address widths
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;

  // register offsets
  localparam logic [7:0] FREQ_HI_OFS   = 8'h40;
  localparam logic [7:0] FREQ_LO_OFS   = 8'h41;
  localparam logic [7:0] PWR_OFS       = 8'h42;
  localparam logic [7:0] TEMP_OFS      = 8'h43;
  localparam logic [7:0] PWR_MIN_OFS   = 8'h50;
  localparam logic [7:0] PWR_MAX_OFS   = 8'h51;
  localparam logic [7:0] LOW_HI_OFS    = 8'h52;
  localparam logic [7:0] LOW_LO_OFS    = 8'h53;
  localparam logic [7:0] HIGH_HI_OFS   = 8'h54;
  localparam logic [7:0] HIGH_LO_OFS   = 8'h55;
  localparam logic [7:0] MIN_SPC_OFS   = 8'h56;
  localparam logic [7:0] RSVD_FIRST    = 8'h57;
  localparam logic [7:0] RSVD_LAST     = 8'h7F;
  localparam logic [7:0] MAKER_FIRST   = 8'h80;

  // reset and fill values
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [15:0] NO_CHANNEL   = 16'h0000;

  // one high word (1000 GHz) equals this many low units (0.1 GHz)
  localparam logic [31:0] HI_SCALE     = 32'h0000_2710;

  // temperature alarm set point and window, 0.01 degC; plain defaults
  localparam logic signed [15:0] TEMP_SETPOINT = 16'sh09C4;
  localparam logic signed [15:0] TEMP_WINDOW   = 16'sh01F4;

  // frequency as a high/low register pair
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } tsrb_freq_t;

  // register port request from the management interface
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tsrb_req_t;

  // fixed capabilities of the source
  typedef struct packed {
    tsrb_freq_t  lowest;
    tsrb_freq_t  highest;
    logic [15:0] min_spacing;
  } tsrb_caps_t;

  // tuning state that sets the frequency
  typedef struct packed {
    logic [15:0]        channel;
    logic signed [15:0] grid;
    tsrb_freq_t         first;
  } tsrb_tune_t;

endpackage : tsrb_pkg

// *** tsrb_freq_calc.sv ***
`timescale 1ns/10ps
// combinational set point: (channel - 1) * grid + first channel frequency
module tsrb_freq_calc
(
  // tuning state
  input  wire tsrb_pkg::tsrb_tune_t i_tune,
  // set point as register pair
  output tsrb_pkg::tsrb_freq_t      o_freq
);

  logic signed [17:0] chan_m1;
  logic signed [33:0] step;
  logic signed [35:0] first;
  logic signed [35:0] total;
  logic        [31:0] total_u;

  // grid counts 100 MHz, which is the low-word unit
  always_comb
  begin
    chan_m1 = $signed({2'h0, i_tune.channel}) - 18'sh1;
    step    = 34'(chan_m1 * i_tune.grid);
    first   = $signed({4'h0, 32'(i_tune.first.hi * tsrb_pkg::HI_SCALE)})
            + $signed({20'h00000, i_tune.first.lo});
    total   = first + 36'(step);
    total_u = total[35] ? 32'h0000_0000 : total[31:0]; // clamp below zero
    o_freq.hi = 16'(total_u / tsrb_pkg::HI_SCALE);
    o_freq.lo = 16'(total_u % tsrb_pkg::HI_SCALE);
  end

endmodule : tsrb_freq_calc

// *** tsrb_temp_alarm.sv ***
`timescale 1ns/10ps
// temperature alarm from the held temperature word
module tsrb_temp_alarm
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // held temperature, 0.01 degC
  input  wire logic [15:0] i_temp,
  // alarm level
  output logic             o_alarm
);

  logic signed [16:0] diff;

  // distance from the set point
  always_comb
  begin
    diff = 17'($signed(i_temp)) - 17'(tsrb_pkg::TEMP_SETPOINT);
  end

  // alarm outside the window, registered
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_alarm <= 1'b0;
    else
      o_alarm <= (diff > 17'(tsrb_pkg::TEMP_WINDOW))
              || (diff < -17'(tsrb_pkg::TEMP_WINDOW)); // RULE_05
  end

endmodule : tsrb_temp_alarm

// *** tsrb_monitor.sv ***
`timescale 1ns/10ps
// port checks for the readback registers
module tsrb_monitor
(
  // clock and reset
  input wire logic                i_core_clk,
  input wire logic                i_sys_rst,
  // request side
  input wire tsrb_pkg::tsrb_req_t i_req,
  input wire logic [15:0]         i_temp_meas,
  // answers
  input wire logic [15:0]         o_rdata,
  input wire logic                o_rvalid,
  input wire logic                o_wr_ignored,
  input wire logic                o_maker_rd,
  input wire logic                o_maker_wr,
  input wire logic [7:0]          o_maker_addr,
  input wire logic [15:0]         o_maker_wdata,
  input wire logic                o_temp_alarm
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // request kinds and a held hot temperature
  sequence s_lo_wr;
    i_req.wr && !i_req.addr[7];
  endsequence
  sequence s_rsvd_rd;
    i_req.rd && i_req.addr >= 8'h57 && i_req.addr <= 8'h7F;
  endsequence
  sequence s_hot;
    ($signed(i_temp_meas) > 16'sh0BB8) [*3];
  endsequence
  sequence s_maker_req;
    o_maker_rd || o_maker_wr;
  endsequence
  // maker strobes carry the request address and data unchanged
  property p_maker_pass;
    s_maker_req |-> o_maker_addr == i_req.addr
      && o_maker_wdata == i_req.wdata;
  endproperty
  a_rd_answer: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  a_no_stray: assert property (!i_req.rd |=> !o_rvalid)
    else $error("answer without read");
  a_wr_refused: assert property (s_lo_wr |=> o_wr_ignored)
    else $error("write not refused");
  a_no_refuse: assert property (!i_req.wr |=> !o_wr_ignored)
    else $error("refusal without write");
  a_rdata_hold: assert property (!i_req.rd |=> $stable(o_rdata))
    else $error("read data moved");
  a_rsvd_zero: assert property (s_rsvd_rd |=> o_rdata == 16'h0000)
    else $error("reserved read not zero");
  a_maker_rd: assert property (o_maker_rd == (i_req.rd && i_req.addr[7]))
    else $error("maker read strobe wrong");
  a_maker_wr: assert property (o_maker_wr == (i_req.wr && i_req.addr[7]))
    else $error("maker write strobe wrong");
  a_maker_pass: assert property (p_maker_pass)
    else $error("maker address or data wrong");
  a_alarm_hot: assert property (s_hot |-> o_temp_alarm)
    else $error("alarm missing");
endmodule : tsrb_monitor

// *** tsrb_host.sv ***
`timescale 1ns/10ps
// host side of the register port
module tsrb_host
(
  // clock
  input wire logic            i_core_clk,
  // answers
  input wire logic [15:0]     i_rdata,
  input wire logic            i_rvalid,
  // request
  output tsrb_pkg::tsrb_req_t o_req
);
  initial o_req = '0;
  // one-cycle read strobe, data taken with the answer
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    o_req <= {1'b1, 1'b0, a, 16'h0000};
    @(posedge i_core_clk);
    o_req <= '0;
    #1;
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hXXXX;
  endtask : rd
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_core_clk);
    o_req <= {1'b0, 1'b1, a, v};
    @(posedge i_core_clk);
    o_req <= '0;
  endtask : wr
endmodule : tsrb_host

// *** tb_tsrb_readback.sv ***
`timescale 1ns/10ps
// readback register bench
module tb_tsrb_readback;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  tsrb_pkg::tsrb_req_t  req;
  tsrb_pkg::tsrb_tune_t tune = {16'h0003, 16'h01F4, 16'h00C2, 16'h06D6};
  tsrb_pkg::tsrb_caps_t caps = {64'h00BF_0000_00C4_1F40, 16'h0001};
  logic [15:0]          pmeas = 16'hF830;
  logic [15:0]          temp = 16'h09C4;
  logic [15:0]          pmin = 16'h1B58;
  logic [15:0]          pmax = 16'h3A98;
  logic [15:0]          rdata, d;
  logic [31:0]          f;
  logic                 rvalid, wign, alarm;
  logic                 mrd, mwr;
  logic [7:0]           maddr, addr;
  logic [15:0]          mwdata, mrdata;
  logic [7:0]           ma_cap = 8'h00;
  logic [15:0]          mw_cap = 16'h0000;
  int                   n_mrd = 0;
  int                   fail_count = 0;
  int                   n_checks = 0;
  always #50 clk = ~clk;
  tsrb_host host (.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_req(req));
  tsrb_readback dut (.i_core_clk(clk), .i_sys_rst(rst), .i_req(req),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_wr_ignored(wign),
    .i_tune(tune), .i_power_meas(pmeas), .i_temp_meas(temp),
    .i_power_min(pmin), .i_power_max(pmax), .i_caps(caps),
    .o_maker_rd(mrd), .o_maker_wr(mwr), .o_maker_addr(maddr),
    .o_maker_wdata(mwdata), .i_maker_rdata(mrdata), .o_temp_alarm(alarm));
  // maker area model: answers a tag and the address, captures writes
  assign mrdata = {8'hA5, maddr};
  always @(posedge clk)
  begin
    if (mrd)
      n_mrd <= n_mrd + 1;
    if (mwr)
    begin
      ma_cap <= maddr;
      mw_cap <= mwdata;
    end
  end
  // expected pair: (channel - 1) * grid + first, in 0.1 GHz
  function automatic logic [31:0] fexp(input tsrb_pkg::tsrb_tune_t t);
    int v;
    v = int'(t.first.hi) * 10000 + int'(t.first.lo);
    v = v + (int'(t.channel) - 1) * int'(t.grid);
    return {16'(v / 10000), 16'(v % 10000)};
  endfunction : fexp
  // compare and count
  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // read one register and compare
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask : rc
  // verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // hang guard
  initial
  begin
    #(2000 * 100);
    fail_count++;
    conclude();
  end
  // test sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    f = fexp(tune);
    rc(8'h40, f[31:16]);
    rc(8'h41, f[15:0]);
    rc(8'h42, 16'hF830);
    rc(8'h43, 16'h09C4);
    rc(8'h50, 16'h1B58);
    rc(8'h51, 16'h3A98);
    for (int i = 0; i < 5; i++)
      rc(8'h52 + 8'(i), caps[79 - 16 * i -: 16]);
    $display("readout test done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      tune.channel <= 16'(3 + i);
      tune.grid    <= 16'(500 - 600 * i);
      repeat (2) @(posedge clk);
      f = fexp(tune);
      rc(8'h40, f[31:16]);
      rc(8'h41, f[15:0]);
    end
    $display("frequency test done");
    for (int i = 0; i < 8; i++)
    begin
      addr = {i[2], 7'h44 ^ 7'(i * 19)};
      rc(addr, addr[7] ? {8'hA5, addr} : 16'h0000);
    end
    chk("maker reads", 16'(n_mrd), 16'h0004);
    $display("reserved test done");
    f = fexp(tune);
    host.wr(8'h40, 16'h1234);
    #1 chk("write refused", {15'h0000, wign}, 16'h0001);
    host.wr(8'h90, 16'h5678);
    #1 chk("maker write data", mw_cap, 16'h5678);
    chk("maker write addr", {8'h00, ma_cap}, 16'h0090);
    chk("maker write kept", {15'h0000, wign}, 16'h0000);
    rc(8'h40, f[31:16]);
    $display("write test done");
    @(posedge clk);
    tune.channel <= 16'h0000;
    repeat (2) @(posedge clk);
    pmin <= 16'h0001;
    rc(8'h50, 16'h1B58);
    @(posedge clk);
    tune.channel <= 16'h0003;
    repeat (2) @(posedge clk);
    rc(8'h50, 16'h0001);
    $display("power range test done");
    @(posedge clk);
    temp <= 16'h0CE4;
    repeat (4) @(posedge clk);
    #1 chk("alarm hot", {15'h0000, alarm}, 16'h0001);
    rc(8'h43, 16'h0CE4);
    @(posedge clk);
    temp <= 16'h09C4;
    repeat (4) @(posedge clk);
    #1 chk("alarm cool", {15'h0000, alarm}, 16'h0000);
    $display("alarm test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    f = fexp(tune);
    rc(8'h40, f[31:16]);
    rc(8'h41, f[15:0]);
    $display("reset test done");
    conclude();
  end
endmodule : tb_tsrb_readback
bind tsrb_readback tsrb_monitor mon (.i_core_clk, .i_sys_rst, .i_req,
  .i_temp_meas, .o_rdata, .o_rvalid, .o_wr_ignored, .o_maker_rd,
  .o_maker_wr, .o_maker_addr, .o_maker_wdata, .o_temp_alarm);
